// ### hec_consts.vh
/*
 Constants for the HDLC error and mode control block: register byte
 offsets, field positions, reset values, FIFO sizes and CRC constants.
 Assumes inclusion by bare name from plain Verilog design files.
*/
`ifndef HEC_CONSTS_VH
`define HEC_CONSTS_VH
// APB byte offsets
`define HEC_OFF_MODE 12'h000
`define HEC_OFF_GEN 12'h004
`define HEC_OFF_CMD 12'h008
`define HEC_OFF_STAT 12'h00C
`define HEC_OFF_RXSTAT 12'h010
`define HEC_OFF_RXLEN 12'h014
`define HEC_OFF_EVENT 12'h018
`define HEC_OFF_CRCERR 12'h01C
`define HEC_OFF_ABORTS 12'h020
`define HEC_OFF_RETRY 12'h024
`define HEC_OFF_DESCIDX 12'h028
// Mode register fields
`define HEC_MODE_RESET 16'h0000
`define HEC_NOF_HI 15
`define HEC_NOF_LO 12
`define HEC_CRC_HI 11
`define HEC_CRC_LO 10
`define HEC_RTE_BIT 9
`define HEC_FSE_BIT 7
`define HEC_DRT_BIT 6
`define HEC_BUS_BIT 5
`define HEC_BRM_BIT 4
`define HEC_MFF_BIT 3
`define HEC_MODE_WMASK 16'hFEF8
// General mode register bits
`define HEC_GEN_ENABLE 0
`define HEC_GEN_RFW 1
`define HEC_GEN_RTS_MODE_SEL 2
`define HEC_GEN_RESET 3'h0
`define HEC_GEN_WMASK 32'h00000007
// Command register bits
`define HEC_CMD_RESUME 0
`define HEC_CMD_HUNT 1
// Rx descriptor status positions
`define HEC_RB_OWN 15
`define HEC_RB_TAB 13
`define HEC_RB_FLAGUSE 12
`define HEC_RB_EOF 11
`define HEC_RB_HEAD 10
`define HEC_RB_CONT 9
`define HEC_RB_DPLL 7
`define HEC_RB_LONG 5
`define HEC_RB_ODD 4
`define HEC_RB_SEVEN 3
`define HEC_RB_CHECK 2
`define HEC_RB_LOST 1
`define HEC_RB_CARRIER 0
`define HEC_RXD_OFF_STAT 3'h0
`define HEC_RXD_OFF_LEN 3'h2
`define HEC_RXD_OFF_PTR 3'h4
// Tx descriptor status positions
`define HEC_TB_STARVED 1
`define HEC_TB_CTSLOST 0
// Event bits
`define HEC_EV_RXF 0
`define HEC_EV_TXE 1
// FIFO sizes in bytes
`define HEC_TXFIFO_CH1 32
`define HEC_TXFIFO_OTHER 16
`define HEC_RXFIFO_WIDE 4
// CRC polynomials and check residues
`define HEC_POLY16 32'h00001021
`define HEC_POLY32 32'h04C11DB7
`define HEC_RES16 32'h00001D0F
`define HEC_RES32 32'hC704DD7B
`define HEC_OVR_LEN 16'h0002
`endif

// ### hec_hdlc_ctrl.v
/*
 HDLC error and mode control for one serial channel: mode register,
 receive error detection with descriptor status, transmit error
 handling with retransmission, RTS/flag control and error counters.
 Assumes an APB master on clk, a serial bit clock and line pins from
 outside the clock domain, and a byte-level transmit data source.
*/
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "hec_consts.vh"
module hec_hdlc_ctrl #(
   parameter CHANNEL_ONE = 1
) (
   input wire clk,
   input wire reset_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire serialClk,
   input wire rxData,
   input wire carrierPin,
   input wire ctsPin,
   input wire addrMatch,
   input wire [7:0] txByte,
   input wire txByteValid,
   input wire txFirstBuf,
   input wire txSecondBuf,
   input wire txLastByte,
   output reg txByteReady,
   output reg txLine,
   output reg rtsOut,
   output reg rxWordValid,
   output reg [31:0] rxWord,
   output reg txErrorEvent,
   output reg rxFrameEvent
);
   localparam [5:0] TX_DEPTH = CHANNEL_ONE ? `HEC_TXFIFO_CH1 : `HEC_TXFIFO_OTHER;
   localparam [1:0] TS_IDLE = 2'h0;
   localparam [1:0] TS_FRAME = 2'h1;
   localparam [1:0] TS_STOP = 2'h2;
   localparam [1:0] TS_WAITCTS = 2'h3;

   // CRC step over one bit, width chosen by mode
   function [31:0] crcBit;
      input [31:0] c;
      input b;
      input wide;
      reg fb;
      begin
         fb = (wide ? c[31] : c[15]) ^ b;
         crcBit = {c[30:0], 1'b0} ^ (fb ? (wide ? `HEC_POLY32 : `HEC_POLY16) : 32'h0);
         if (!wide) begin
            crcBit[31:16] = 16'h0000;
         end
      end
   endfunction

   // Wrapping 16-bit increment
   function [15:0] inc16;
      input [15:0] v;
      begin
         inc16 = v + 16'h0001;
      end
   endfunction

   reg [15:0] modeReg_r;
   reg [2:0] genReg_r;
   reg [15:0] crcErrCnt_r, abortCnt_r, retryCnt_r;
   reg [15:0] rxStat_r, rxLen_r, descIdx_r;
   reg [1:0] txStat_r, events_r;
   reg [1:0] sckSync_r, rxSync_r, cdSync_r, ctsSync_r;
   reg sckPrev_r;
   reg [1:0] txState_r;
   reg [3:0] flagLeft_r;
   reg [2:0] onesRun_r;
   reg inFrame_r, hunt_r, pendDel_r;
   reg [7:0] rxShift_r;
   reg [2:0] bitCnt_r;
   reg [31:0] crc_r, crcByte_r;
   reg [15:0] byteCnt_r;
   reg [1:0] wordBytes_r;
   reg rxHeld_r, rxFull_r;
   reg [5:0] txCount_r;
   reg [7:0] txSh_r;
   reg [3:0] txBits_r;
   reg retryArm_r, rtsDly_r;
   reg [15:0] rxClose;
   reg rxCloseEn;

   wire enable = genReg_r[`HEC_GEN_ENABLE];
   wire wide = modeReg_r[`HEC_CRC_HI];
   wire bitTick = sckSync_r[1] & ~sckPrev_r;
   wire rxBit = rxSync_r[1];
   wire apbAcc = psel & penable;
   wire apbWr = apbAcc & pwrite & pready;
   wire [3:0] min_flag_count = modeReg_r[`HEC_NOF_HI:`HEC_NOF_LO];
   wire fseOn = modeReg_r[`HEC_FSE_BIT] & genReg_r[`HEC_GEN_RTS_MODE_SEL];
   wire [3:0] flagsNeeded = (fseOn && min_flag_count != 4'h0) ? min_flag_count - 4'h1 : min_flag_count;
   wire txActive = (txState_r == TS_FRAME);
   wire rxMuted = modeReg_r[`HEC_DRT_BIT] & rtsOut;
   wire resumeCmd = apbWr && paddr == `HEC_OFF_CMD && pwdata[`HEC_CMD_RESUME];
   wire huntCmd = apbWr && paddr == `HEC_OFF_CMD && pwdata[`HEC_CMD_HUNT];
   wire canPreset = ~enable;
   wire [31:0] crcRes = wide ? `HEC_RES32 : `HEC_RES16;
   wire wordReady = genReg_r[`HEC_GEN_RFW] ? (wordBytes_r == 2'h3) : 1'b1;

   // Synchronise serial clock and line pins
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sckSync_r <= 2'h0;
         rxSync_r <= 2'h3;
         cdSync_r <= 2'h0;
         ctsSync_r <= 2'h0;
         sckPrev_r <= 1'b0;
      end else begin
         sckSync_r <= {sckSync_r[0], serialClk};
         rxSync_r <= {rxSync_r[0], rxData};
         cdSync_r <= {cdSync_r[0], carrierPin};
         ctsSync_r <= {ctsSync_r[0], ctsPin};
         sckPrev_r <= sckSync_r[1];
      end
   end

   // APB slave, zero wait: one access cycle
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         modeReg_r <= `HEC_MODE_RESET;
         genReg_r <= `HEC_GEN_RESET;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel & ~penable) begin
            case (paddr)
               `HEC_OFF_MODE: prdata <= {16'h0, modeReg_r};
               `HEC_OFF_GEN: prdata <= {29'h0, genReg_r};
               `HEC_OFF_CMD: prdata <= 32'h0;
               `HEC_OFF_STAT: prdata <= {24'h0, hunt_r, inFrame_r, txState_r, 2'h0, txStat_r};
               `HEC_OFF_RXSTAT: prdata <= {16'h0, rxStat_r};
               `HEC_OFF_RXLEN: prdata <= {16'h0, rxLen_r};
               `HEC_OFF_EVENT: prdata <= {30'h0, events_r};
               `HEC_OFF_CRCERR: prdata <= {16'h0, crcErrCnt_r};
               `HEC_OFF_ABORTS: prdata <= {16'h0, abortCnt_r};
               `HEC_OFF_RETRY: prdata <= {16'h0, retryCnt_r};
               `HEC_OFF_DESCIDX: prdata <= {16'h0, descIdx_r};
               default: begin
                  prdata <= 32'h0;
                  pslverr <= 1'b1;
               end
            endcase
         end
         if (apbWr && paddr == `HEC_OFF_MODE) begin
            modeReg_r <= pwdata[15:0] & `HEC_MODE_WMASK;
         end
         if (apbWr && paddr == `HEC_OFF_GEN) begin
            genReg_r <= pwdata[2:0];
         end
      end
   end

   // Receive close status: carrier beats abort beats overrun
   always @* begin
      rxClose = 16'h0000;
      rxCloseEn = 1'b0;
      if (inFrame_r && !cdSync_r[1]) begin
         rxClose[`HEC_RB_CARRIER] = 1'b1;
         rxCloseEn = 1'b1;
      end else if (inFrame_r && byteCnt_r != 16'h0 && bitTick && rxBit && onesRun_r == 3'h6) begin
         rxClose[`HEC_RB_SEVEN] = 1'b1;
         rxCloseEn = 1'b1;
      end else if (inFrame_r && rxFull_r && bitTick && bitCnt_r == 3'h7 && !(rxBit && onesRun_r == 3'h5)) begin
         rxClose[`HEC_RB_LOST] = 1'b1;
         rxCloseEn = 1'b1;
      end
   end

   // Receiver: flags, abort, unstuffing, CRC, errors, descriptor status
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         onesRun_r <= 3'h0;
         inFrame_r <= 1'b0;
         hunt_r <= 1'b1;
         rxShift_r <= 8'h00;
         bitCnt_r <= 3'h0;
         crc_r <= 32'hFFFFFFFF;
         crcByte_r <= 32'hFFFFFFFF;
         byteCnt_r <= 16'h0;
         wordBytes_r <= 2'h0;
         rxHeld_r <= 1'b0;
         rxFull_r <= 1'b0;
         rxStat_r <= 16'h0;
         rxLen_r <= 16'h0;
         descIdx_r <= 16'h0;
         crcErrCnt_r <= 16'h0;
         abortCnt_r <= 16'h0;
         rxWord <= 32'h0;
         rxWordValid <= 1'b0;
         rxFrameEvent <= 1'b0;
         pendDel_r <= 1'b0;
      end else begin
         rxWordValid <= 1'b0;
         rxFrameEvent <= 1'b0;
         rxFull_r <= rxHeld_r & ~rxWordValid;
         if (rxCloseEn || huntCmd) begin
            // Error close or hunt command: own bit cleared, last flag, enter hunt
            rxStat_r <= rxClose | (16'h1 << `HEC_RB_EOF);
            rxLen_r <= (rxClose[`HEC_RB_LOST] && !addrMatch) ? `HEC_OVR_LEN : byteCnt_r;
            rxFrameEvent <= rxCloseEn;
            if (rxClose[`HEC_RB_SEVEN]) begin
               abortCnt_r <= inc16(abortCnt_r);
            end
            descIdx_r <= inc16(descIdx_r);
            inFrame_r <= 1'b0;
            hunt_r <= 1'b1;
            onesRun_r <= 3'h0;
            crc_r <= 32'hFFFFFFFF;
         end else if (bitTick && !rxMuted) begin
            if (rxBit) begin
               onesRun_r <= (onesRun_r == 3'h7) ? onesRun_r : onesRun_r + 3'h1;
            end else begin
               onesRun_r <= 3'h0;
            end
            if (!rxBit && onesRun_r == 3'h6) begin
               // Flag: closes a frame or opens one; outside a frame aborts are silent
               if (inFrame_r && byteCnt_r != 16'h0) begin
                  rxStat_r <= (16'h1 << `HEC_RB_EOF)
                     | ((bitCnt_r != 3'h7) ? (16'h1 << `HEC_RB_ODD) : 16'h0)
                     | ((bitCnt_r == 3'h7 && crcByte_r != crcRes)
                     ? (16'h1 << `HEC_RB_CHECK) : 16'h0);
                  if (bitCnt_r == 3'h7 && crcByte_r != crcRes) begin
                     crcErrCnt_r <= inc16(crcErrCnt_r);
                  end
                  rxLen_r <= byteCnt_r;
                  rxFrameEvent <= 1'b1;
                  descIdx_r <= inc16(descIdx_r);
               end
               // Back-to-back frame opens on the same flag
               inFrame_r <= 1'b1;
               hunt_r <= 1'b0;
               bitCnt_r <= 3'h0;
               byteCnt_r <= 16'h0;
               wordBytes_r <= 2'h0;
               crc_r <= 32'hFFFFFFFF;
            end else if (rxBit && onesRun_r >= 3'h6) begin
               inFrame_r <= 1'b0;
            end else if (inFrame_r && !(!rxBit && onesRun_r == 3'h5)) begin
               // LSB first assembly, CRC over every data bit
               rxShift_r <= {rxBit, rxShift_r[7:1]};
               crc_r <= crcBit(crc_r, rxBit, wide);
               bitCnt_r <= bitCnt_r + 3'h1;
               if (bitCnt_r == 3'h7) begin
                  byteCnt_r <= inc16(byteCnt_r);
                  crcByte_r <= crcBit(crc_r, rxBit, wide);
                  rxWord <= {rxWord[23:0], rxBit, rxShift_r[7:1]};
                  wordBytes_r <= wordBytes_r + 2'h1;
                  if (wordReady) begin
                     rxWordValid <= 1'b1;
                     rxHeld_r <= 1'b1;
                  end
               end
            end
         end
         if (apbWr && canPreset && paddr == `HEC_OFF_CRCERR) begin
            crcErrCnt_r <= pwdata[15:0];
         end
         if (apbWr && canPreset && paddr == `HEC_OFF_ABORTS) begin
            abortCnt_r <= pwdata[15:0];
         end
         pendDel_r <= rxWordValid;
         if (pendDel_r) begin
            rxHeld_r <= 1'b0;
         end
      end
   end

   // Transmitter: byte FIFO count, errors, retransmission, flags, RTS
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         txState_r <= TS_IDLE;
         txStat_r <= 2'h0;
         events_r <= 2'h0;
         retryCnt_r <= 16'h0;
         txCount_r <= 6'h0;
         txSh_r <= 8'hFF;
         txBits_r <= 4'h0;
         flagLeft_r <= 4'h0;
         retryArm_r <= 1'b0;
         rtsDly_r <= 1'b0;
         txByteReady <= 1'b0;
         txLine <= 1'b1;
         rtsOut <= 1'b0;
         txErrorEvent <= 1'b0;
      end else begin
         txErrorEvent <= 1'b0;
         txByteReady <= txActive && (txCount_r + {5'h0, txByteValid & txByteReady}) < TX_DEPTH;
         // Write-one clear first, so a set in the same cycle wins
         if (apbWr && paddr == `HEC_OFF_EVENT && pwdata[`HEC_EV_TXE]) begin
            events_r[`HEC_EV_TXE] <= 1'b0;
         end
         case (txState_r)
            TS_IDLE: begin
               if (bitTick && flagLeft_r != 4'h0) begin
                  flagLeft_r <= flagLeft_r - 4'h1;
               end
               if (enable && txByteValid && flagLeft_r == 4'h0) begin
                  txState_r <= TS_FRAME;
                  retryArm_r <= txFirstBuf | txSecondBuf;
               end
            end
            TS_FRAME: begin
               if (bitTick) begin
                  txLine <= txSh_r[0];
                  txSh_r <= {1'b1, txSh_r[7:1]};
                  txBits_r <= txBits_r + 4'h1;
               end
               if (txByteValid && txByteReady) begin
                  txCount_r <= txCount_r + 6'h1;
               end
               if (!ctsSync_r[1]) begin
                  txStat_r[`HEC_TB_CTSLOST] <= 1'b1;
                  txErrorEvent <= 1'b1;
                  events_r[`HEC_EV_TXE] <= 1'b1;
                  if (modeReg_r[`HEC_RTE_BIT] && retryArm_r) begin
                     txState_r <= TS_WAITCTS;
                  end else begin
                     txState_r <= TS_STOP;
                  end
               end else if (bitTick && txBits_r == 4'h7 && txCount_r == 6'h0 && !txLastByte) begin
                  txStat_r[`HEC_TB_STARVED] <= 1'b1;
                  txErrorEvent <= 1'b1;
                  events_r[`HEC_EV_TXE] <= 1'b1;
                  txState_r <= TS_STOP;
               end else if (txLastByte && txCount_r == 6'h0) begin
                  txState_r <= TS_IDLE;
                  flagLeft_r <= flagsNeeded;
               end
               if (bitTick && txBits_r == 4'h7) begin
                  txBits_r <= 4'h0;
                  txSh_r <= txByte;
                  if (txCount_r != 6'h0) begin
                     txCount_r <= txCount_r - 6'h1;
                  end
               end
            end
            TS_WAITCTS: begin
               txLine <= 1'b1;
               txCount_r <= 6'h0;
               if (ctsSync_r[1]) begin
                  retryCnt_r <= inc16(retryCnt_r);
                  txState_r <= TS_FRAME;
               end
            end
            TS_STOP: begin
               txLine <= 1'b1;
               txCount_r <= 6'h0;
               if (resumeCmd) begin
                  txState_r <= TS_IDLE;
                  txStat_r <= 2'h0;
               end
            end
            default: txState_r <= TS_IDLE;
         endcase
         if (bitTick) begin
            rtsDly_r <= txActive;
         end
         // Bus mode: optional one bit delay of RTS
         if (modeReg_r[`HEC_BUS_BIT] && modeReg_r[`HEC_BRM_BIT]) begin
            rtsOut <= rtsDly_r & txActive;
         end else begin
            rtsOut <= txActive;
         end
         if (rxFrameEvent) begin
            events_r[`HEC_EV_RXF] <= 1'b1;
         end else if (apbWr && paddr == `HEC_OFF_EVENT && pwdata[`HEC_EV_RXF]) begin
            events_r[`HEC_EV_RXF] <= 1'b0;
         end
         if (apbWr && canPreset && paddr == `HEC_OFF_RETRY) begin
            retryCnt_r <= pwdata[15:0];
         end
      end
   end
endmodule
`default_nettype wire

// ### hec_hdlc_ctrl_sva.sv
/* Checker for the HDLC error and mode control block: APB answer timing,
   register read-back, reserved and counter widths, event pulse shapes.
   Assumes it is bound to hec_hdlc_ctrl and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
`include "hec_consts.vh"
module hec_hdlc_ctrl_sva (
   input wire clk,
   input wire reset_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire rxWordValid,
   input wire txErrorEvent,
   input wire rxFrameEvent
);
   logic [15:0] modeShadow_r;
   wire rdAcc;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // Read access completing in this cycle
   assign rdAcc = psel && penable && pready && !pwrite;
   // Mirror of accepted mode writes with reserved bits dropped
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         modeShadow_r <= `HEC_MODE_RESET;
      end else if (psel && penable && pready && pwrite && paddr == `HEC_OFF_MODE) begin
         modeShadow_r <= pwdata[15:0] & `HEC_MODE_WMASK;
      end
   end
   property p_readyAfterSetup;
      psel && !penable |=> pready;
   endproperty
   a_readyAfterSetup: assert property (p_readyAfterSetup) else $error("pready late");
   property p_readyPulse;
      pready |=> !pready;
   endproperty
   a_readyPulse: assert property (p_readyPulse) else $error("pready too long");
   property p_errZero;
      pslverr |-> pready && (pwrite || prdata == 32'h0);
   endproperty
   a_errZero: assert property (p_errZero) else $error("bad refused access");
   property p_modeRead;
      rdAcc && paddr == `HEC_OFF_MODE |-> prdata == {16'h0000, modeShadow_r};
   endproperty
   a_modeRead: assert property (p_modeRead) else $error("mode read-back wrong");
   property p_cntWidth;
      rdAcc && (paddr == `HEC_OFF_CRCERR || paddr == `HEC_OFF_ABORTS
         || paddr == `HEC_OFF_RETRY) |-> prdata[31:16] == 16'h0000;
   endproperty
   a_cntWidth: assert property (p_cntWidth) else $error("counter wider than 16");
   property p_rxStatRsv;
      rdAcc && paddr == `HEC_OFF_RXSTAT |-> prdata[31:16] == 16'h0000
         && !prdata[14] && !prdata[8] && !prdata[6];
   endproperty
   a_rxStatRsv: assert property (p_rxStatRsv) else $error("status reserved set");
   property p_txEvPulse;
      $rose(txErrorEvent) |=> $fell(txErrorEvent);
   endproperty
   a_txEvPulse: assert property (p_txEvPulse) else $error("tx event too long");
   property p_rxEvPulse;
      rxFrameEvent |=> !rxFrameEvent;
   endproperty
   a_rxEvPulse: assert property (p_rxEvPulse) else $error("rx event too long");
   property p_wordPulse;
      rxWordValid |=> !rxWordValid;
   endproperty
   a_wordPulse: assert property (p_wordPulse) else $error("word strobe too long");
endmodule
bind hec_hdlc_ctrl hec_hdlc_ctrl_sva u_sva (.clk(clk), .reset_n(reset_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .rxWordValid(rxWordValid),
   .txErrorEvent(txErrorEvent), .rxFrameEvent(rxFrameEvent));
`default_nettype wire

// ### hec_line_partner.sv
/* Remote HDLC station on the synchronous serial line: bit clock,
   received data with zero insertion, carrier and clear-to-send.
   Assumes the bench calls its tasks and drives clkOn for transmit. */
`timescale 1ns/1ns
`default_nettype none
module hec_line_partner (
   output logic serialClk,
   output logic rxData,
   output logic carrierPin,
   output logic ctsPin
);
   logic clkOn;
   int ones;
   // Idle line: marks, carrier and clear-to-send present
   initial begin
      serialClk = 1'b0;
      rxData = 1'b1;
      carrierPin = 1'b1;
      ctsPin = 1'b1;
      clkOn = 1'b0;
      ones = 0;
   end
   // Bit clock, still while no traffic is due
   always begin
      #80;
      serialClk = clkOn ? ~serialClk : 1'b0;
   end
   // One bit per falling edge; a zero follows five stuffed ones
   task automatic putBit(input logic b, input logic stuff);
      @(negedge serialClk);
      rxData = b;
      ones = (b && stuff) ? ones + 1 : 0;
      if (ones == 5) begin
         @(negedge serialClk);
         rxData = 1'b0;
         ones = 0;
      end
   endtask
   // Octets leave least significant bit first
   task automatic putByte(input logic [7:0] b, input logic stuff);
      for (int i = 0; i < 8; i++) putBit(b[i], stuff);
   endtask
   // Kind 0 bad check field, 1 abort, 2 carrier drop, 3 odd bit count
   task automatic sendFrame(input int kind, input logic [31:0] pay);
      clkOn = 1'b1;
      putByte(8'h7E, 1'b0);
      for (int i = 0; i < 4; i++) putByte(pay[8*i +: 8], 1'b1);
      if (kind == 0) begin
         for (int i = 15; i >= 0; i--) putBit(~pay[i], 1'b1);
      end
      if (kind == 1) begin
         for (int i = 0; i < 8; i++) putBit(1'b1, 1'b0);
      end
      if (kind == 2) begin
         carrierPin = 1'b0;
         for (int i = 0; i < 4; i++) putBit(1'b1, 1'b0);
         carrierPin = 1'b1;
      end
      if (kind == 3) begin
         for (int i = 0; i < 3; i++) putBit(1'b0, 1'b1);
      end
      if (kind == 0 || kind == 3) putByte(8'h7E, 1'b0);
      for (int i = 0; i < 16; i++) putBit(1'b1, 1'b0);
      clkOn = 1'b0;
   endtask
endmodule
`default_nettype wire

// ### tb_hdlc_error_and_mode_control.sv
/* Self-checking bench: mode register, counters, receive error reports
   and transmit errors of the HDLC error and mode control block.
   Assumes the line partner model and the design constants header. */
`timescale 1ns/1ns
`default_nettype none
`include "hec_consts.vh"
module tb_hdlc_error_and_mode_control;
   logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rdData, w;
   logic [7:0] txByte = 8'h00, firstByte;
   logic txByteValid = 1'b0, txFirstBuf = 1'b0, rdErr;
   wire [31:0] prdata, rxWord;
   wire pready, pslverr, serialClk, rxData, carrierPin, ctsPin, txByteReady;
   wire txLine, rtsOut, rxWordValid, txErrorEvent, rxFrameEvent;
   int n_errors = 0, compares = 0, cycles = 0, wordCnt = 0;
   hec_hdlc_ctrl DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serialClk(serialClk), .rxData(rxData), .carrierPin(carrierPin),
      .ctsPin(ctsPin), .addrMatch(1'b1), .txByte(txByte), .txByteValid(txByteValid),
      .txFirstBuf(txFirstBuf), .txSecondBuf(1'b0), .txLastByte(1'b0),
      .txByteReady(txByteReady), .txLine(txLine), .rtsOut(rtsOut),
      .rxWordValid(rxWordValid), .rxWord(rxWord), .txErrorEvent(txErrorEvent),
      .rxFrameEvent(rxFrameEvent));
   hec_line_partner line (.serialClk(serialClk), .rxData(rxData),
      .carrierPin(carrierPin), .ctsPin(ctsPin));
   always #5 clk = ~clk;
   // Run-length guard and first received byte of each frame
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (rxWordValid === 1'b1 && wordCnt == 0) firstByte <= rxWord[7:0];
      if (rxWordValid === 1'b1) wordCnt <= wordCnt + 1;
      if (cycles == 60000) begin
         n_errors = n_errors + 1;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer, idle cycle before it so requests never collide
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdChk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdData & m, e);
   endtask
   task automatic push(input logic [7:0] b);
      int n;
      n = 0;
      txByte <= b;
      txByteValid <= 1'b1;
      txFirstBuf <= 1'b1;
      @(posedge clk);
      while (txByteReady !== 1'b1 && n < 5000) begin
         n++;
         @(posedge clk);
      end
   endtask
   function automatic logic [31:0] errMask(input int k);
      case (k)
         0: errMask = 32'h1 << `HEC_RB_CHECK;
         1: errMask = 32'h1 << `HEC_RB_SEVEN;
         2: errMask = 32'h1 << `HEC_RB_CARRIER;
         default: errMask = 32'h1 << `HEC_RB_ODD;
      endcase
   endfunction
   // Main sequence: registers, receive errors, transmit errors
   initial begin
      void'($urandom(32'h8C4F26F2));
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      rdChk(`HEC_OFF_MODE, 32'hFFFFFFFF, 32'h0);
      for (int k = 0; k < 4; k++) begin
         w = $urandom;
         w[11:10] = k[1:0];
         apb(1'b1, `HEC_OFF_MODE, w);
         rdChk(`HEC_OFF_MODE, 32'hFFFFFFFF, {16'h0, w[15:0] & `HEC_MODE_WMASK});
      end
      apb(1'b1, `HEC_OFF_MODE, 32'h4000);
      apb(1'b0, 12'h0FC, 32'h0);
      chk({31'h0, rdErr}, 32'h1);
      chk(rdData, 32'h0);
      apb(1'b1, `HEC_OFF_CRCERR, 32'h1234);
      rdChk(`HEC_OFF_CRCERR, 32'hFFFF, 32'h1234);
      apb(1'b1, `HEC_OFF_CRCERR, 32'h0);
      apb(1'b1, `HEC_OFF_GEN, 32'h1);
      apb(1'b1, `HEC_OFF_CRCERR, 32'h55);
      rdChk(`HEC_OFF_CRCERR, 32'hFFFF, 32'h0);
      rdChk(`HEC_OFF_RETRY, 32'hFFFF, 32'h0);
      for (int k = 0; k < 4; k++) begin
         w = $urandom;
         wordCnt = 0;
         line.sendFrame(k, w);
         repeat (20) @(posedge clk);
         chk({24'h0, firstByte}, {24'h0, w[7:0]});
         rdChk(`HEC_OFF_RXSTAT, errMask(k) | 32'h8000, errMask(k));
         rdChk(`HEC_OFF_EVENT, 32'h1, 32'h1);
         apb(1'b1, `HEC_OFF_EVENT, 32'h1);
         if (k == 0) rdChk(`HEC_OFF_CRCERR, 32'hFFFF, 32'h1);
      end
      rdChk(`HEC_OFF_ABORTS, 32'hFFFF, 32'h1);
      line.clkOn = 1'b1;
      for (int k = 0; k < 3; k++) begin
         if (k == 2) apb(1'b1, `HEC_OFF_MODE, 32'h4200);
         for (int i = 0; i < (k == 2 ? 37 : 3); i++) begin
            w = $urandom;
            push(w[7:0]);
         end
         chk({31'h0, rtsOut}, 32'h1);
         if (k != 0) line.ctsPin = 1'b0;
         else txByteValid <= 1'b0;
         for (int n = 0; n < 8000 && txErrorEvent !== 1'b1; n++) @(posedge clk);
         chk({31'h0, txErrorEvent}, 32'h1);
         if (k != 0) txByteValid <= 1'b0;
         line.ctsPin = 1'b1;
         rdChk(`HEC_OFF_STAT, 32'h3, 32'h1 << (k == 0 ? `HEC_TB_STARVED : `HEC_TB_CTSLOST));
         if (k < 2) chk({31'h0, txLine}, 32'h1);
         rdChk(`HEC_OFF_EVENT, 32'h2, 32'h2);
         rdChk(`HEC_OFF_RETRY, 32'hFFFF, k == 2 ? 32'h1 : 32'h0);
         apb(1'b1, `HEC_OFF_EVENT, 32'h2);
         apb(1'b1, `HEC_OFF_CMD, 32'h1);
      end
      line.clkOn = 1'b0;
      end_of_test();
   end
endmodule
`default_nettype wire
